// File: design/udg_consts.svh
// constants of the usb device global event block
//
// Functional notes
// - setting remote_resume_request drives upstream resume toward the host
// - remote_resume_request self-clears on bus reset or resume done; writing zero ignored
// - low_speed_force one selects low speed, zero selects full speed
// - low_speed_force writable while disabled or frozen; disable does not reset it
// - bus_idle_flag sets after three frame periods of idle j state
// - raising line activity clears bus idle flag and vice versa
// - each start of frame sets the flag and loads the frame number
// - end of bus reset sets reset_end_flag
// - line activity flag sets on filtered non-idle lines, but not while driving upstream resume, even with clock frozen
// - valid host end of resume sets resume_end_flag
// - sending upstream resume sets upstream_resume_sent_flag
// - endpoint summary flags 0..6 follow endpoint interrupt requests
// - dma summary flags 1..6 follow dma channel interrupt sources
// - a flag reaches the interrupt only while its enable is one
// - clear register write-one clears bus flags; reads zero
// - set register write-one forces bus or dma flags; reads zero
// - flag register layout: bus 0..6, endpoints 12..18, dma 25..30, reset zero
// - enable clear register write-one clears enable bits; reads zero
// - enable set register write-one sets enable bits
`ifndef UDG_CONSTS_SVH
`define UDG_CONSTS_SVH
`define UDG_OFF_CTRL      6'h00
`define UDG_OFF_FLAGS     6'h04
`define UDG_OFF_CLEAR     6'h08
`define UDG_OFF_SET       6'h0c
`define UDG_OFF_ENABLE    6'h10
`define UDG_OFF_EN_CLEAR  6'h14
`define UDG_OFF_EN_SET    6'h18
`define UDG_BIT_RESUME    9
`define UDG_BIT_LOW_SPEED 12
`define UDG_BIT_IDLE      0
`define UDG_BIT_SOF       2
`define UDG_BIT_RST       3
`define UDG_BIT_WAKE      4
`define UDG_BIT_RSM       5
`define UDG_BIT_UPR       6
`define UDG_BUS_MASK      32'h0000007d
`define UDG_EP_LSB        12
`define UDG_DMA_LSB       25
`define UDG_VALID_MASK    32'h7e07f07d
`define UDG_IDLE_MS       3
`define UDG_CLK_KHZ       200000
`define UDG_IDLE_CYCLES   (`UDG_IDLE_MS * `UDG_CLK_KHZ)
`endif

// File: design/udg_pkg.sv
// types of the usb device global event block
package udg_pkg;
  typedef enum logic [1:0] {
    UDG_RES_IDLE = 2'b00,
    UDG_RES_SEND = 2'b01
  } udg_res_t;

  typedef struct packed {
    logic [5:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } udg_avm_req_t;

  typedef struct packed {
    logic        sof_seen;
    logic [10:0] frame_number;
    logic        reset_end;
    logic        bus_reset;
    logic        line_j_idle;
    logic        line_activity;
    logic        resume_end;
    logic        resume_done;
    logic [6:0]  ep_irq;
    logic [5:0]  dma_irq;
  } udg_link_ev_t;
endpackage

// File: design/udg_global_irq.sv
// global event flags, enables and control bits of a usb device controller
`timescale 1ns/100ps
`include "udg_consts.svh"
module udg_global_irq #(
  parameter int unsigned IDLE_CYCLES = `UDG_IDLE_CYCLES
) (
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  input  wire udg_pkg::udg_avm_req_t avm_req,
  output logic [31:0]                avm_readdata,
  output logic                       avm_waitrequest,
  input  wire udg_pkg::udg_link_ev_t link_ev,
  output logic                       upstream_resume_drive,
  output logic                       low_speed_mode,
  output logic [10:0]                frame_number_field,
  output logic                       usb_irq
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0]      flags;
    logic [31:0]      enables;
    logic             remote_resume_request;
    logic             low_speed_force;
    logic [10:0]      frame_number;
    logic [31:0]      idle_cnt;
    udg_pkg::udg_res_t res_state;
    logic             ack;
    logic [31:0]      rdata;
  } udg_state_t;

  udg_state_t st_reg;
  udg_state_t st_next;

  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] clr_w;
  logic [31:0] set_w;
  logic [31:0] hw_set;
  logic        idle_done;
  logic        wake_set;
  logic        idle_set;

  // expand byte enables into a bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [31:0] wdata_at(input udg_pkg::udg_avm_req_t r,
                                           input logic [5:0] off);
    wdata_at = (r.write && r.address == off) ? (r.writedata & be_mask(r.byteenable)) : 32'h0;
  endfunction

  // ---------------------------------------------------------------
  // bus side
  // ---------------------------------------------------------------
  // one wait cycle per access; a write lands on the edge where waitrequest is low
  assign wr_hit          = avm_req.write && st_reg.ack;
  assign rd_hit          = avm_req.read && !st_reg.ack;
  assign avm_waitrequest = (avm_req.read || avm_req.write) && !st_reg.ack;
  assign avm_readdata    = st_reg.rdata;
  assign clr_w           = wr_hit ? wdata_at(avm_req, `UDG_OFF_CLEAR) : 32'h0;
  assign set_w           = wr_hit ? wdata_at(avm_req, `UDG_OFF_SET) : 32'h0;

  // ---------------------------------------------------------------
  // event logic
  // ---------------------------------------------------------------
  assign idle_done = link_ev.line_j_idle && (st_reg.idle_cnt == IDLE_CYCLES - 1);
  // line activity is a level from the filtered wake detector, so a frozen clock only
  // delays capture; the detector itself runs without this clock
  assign wake_set  = (link_ev.line_activity && !upstream_resume_drive)
                   || set_w[`UDG_BIT_WAKE];
  assign idle_set  = idle_done || set_w[`UDG_BIT_IDLE];

  always_comb begin
    hw_set = 32'h0;
    hw_set[`UDG_BIT_IDLE] = idle_set;
    hw_set[`UDG_BIT_SOF]  = link_ev.sof_seen || set_w[`UDG_BIT_SOF];
    hw_set[`UDG_BIT_RST]  = link_ev.reset_end || set_w[`UDG_BIT_RST];
    hw_set[`UDG_BIT_WAKE] = wake_set;
    hw_set[`UDG_BIT_RSM]  = link_ev.resume_end || set_w[`UDG_BIT_RSM];
    hw_set[`UDG_BIT_UPR]  = (st_reg.res_state == udg_pkg::UDG_RES_IDLE
                             && st_reg.remote_resume_request)
                            || set_w[`UDG_BIT_UPR];
    hw_set[`UDG_DMA_LSB +: 6] = set_w[`UDG_DMA_LSB +: 6];
  end

  always_comb begin
    st_next = st_reg;
    st_next.ack = (avm_req.read || avm_req.write) && !st_reg.ack;
    // flags: clear first, set after so a set wins
    st_next.flags = (st_reg.flags & ~(clr_w & `UDG_BUS_MASK)) | (hw_set & `UDG_VALID_MASK);
    if (wake_set && !idle_set) begin
      st_next.flags[`UDG_BIT_IDLE] = 1'b0;
    end
    if (idle_set && !wake_set) begin
      st_next.flags[`UDG_BIT_WAKE] = 1'b0;
    end
    st_next.flags[`UDG_EP_LSB +: 7] = link_ev.ep_irq;
    // dma summary follows the source; a test force sets the bit for one cycle only, after which it shows the source
    st_next.flags[`UDG_DMA_LSB +: 6] = link_ev.dma_irq
                                      | (st_reg.flags[`UDG_DMA_LSB +: 6] & link_ev.dma_irq)
                                      | set_w[`UDG_DMA_LSB +: 6];
    st_next.enables = (st_reg.enables & ~(wr_hit ? wdata_at(avm_req, `UDG_OFF_EN_CLEAR) : 32'h0))
                    | (wr_hit ? wdata_at(avm_req, `UDG_OFF_EN_SET) : 32'h0);
    st_next.enables = st_next.enables & `UDG_VALID_MASK;
    if (link_ev.line_j_idle && !idle_done) begin
      st_next.idle_cnt = st_reg.idle_cnt + 32'h1;
    end else begin
      st_next.idle_cnt = 32'h0;
    end
    if (link_ev.sof_seen) begin
      st_next.frame_number = link_ev.frame_number;
    end
    if (wr_hit && avm_req.address == `UDG_OFF_CTRL && avm_req.byteenable[1]) begin
      // only a one is taken; the low-speed bit has no enable or freeze gating
      if (avm_req.writedata[`UDG_BIT_RESUME]) begin
        st_next.remote_resume_request = 1'b1;
      end
      st_next.low_speed_force = avm_req.writedata[`UDG_BIT_LOW_SPEED];
    end
    case (st_reg.res_state)
      udg_pkg::UDG_RES_IDLE: begin
        if (st_reg.remote_resume_request) begin
          st_next.res_state = udg_pkg::UDG_RES_SEND;
        end
      end
      udg_pkg::UDG_RES_SEND: begin
        if (link_ev.resume_done || link_ev.bus_reset) begin
          st_next.res_state = udg_pkg::UDG_RES_IDLE;
          st_next.remote_resume_request = 1'b0;
        end
      end
      default: st_next.res_state = udg_pkg::UDG_RES_IDLE;
    endcase
    if (link_ev.bus_reset) begin
      st_next.remote_resume_request = 1'b0;
    end
    st_next.rdata = 32'h0;
    if (rd_hit) begin
      case (avm_req.address)
        `UDG_OFF_CTRL: begin
          st_next.rdata[`UDG_BIT_RESUME] = st_reg.remote_resume_request;
          st_next.rdata[`UDG_BIT_LOW_SPEED] = st_reg.low_speed_force;
        end
        `UDG_OFF_FLAGS:  st_next.rdata = st_reg.flags;
        `UDG_OFF_ENABLE: st_next.rdata = st_reg.enables;
        default:         st_next.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign upstream_resume_drive = (st_reg.res_state == udg_pkg::UDG_RES_SEND);
  assign low_speed_mode        = st_reg.low_speed_force;
  assign frame_number_field    = st_reg.frame_number;
  assign usb_irq               = |(st_reg.flags & st_reg.enables);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_req_resume;
    st_reg.remote_resume_request && st_reg.res_state == udg_pkg::UDG_RES_IDLE;
  endsequence

  sequence s_driving;
    upstream_resume_drive;
  endsequence

  sequence s_ctrl_write;
    wr_hit && avm_req.address == `UDG_OFF_CTRL && avm_req.byteenable[1];
  endsequence

  sequence s_resume_done;
    st_reg.res_state == udg_pkg::UDG_RES_SEND && link_ev.resume_done;
  endsequence

  sequence s_no_resume_end;
    !link_ev.bus_reset && !link_ev.resume_done;
  endsequence

  AST_RESUME_DRIVE: assert property (@(posedge core_clk) disable iff (srst)
    s_req_resume |=> s_driving)
    else $error("upstream resume not driven after request");

  AST_RESUME_SELF_CLEAR: assert property (@(posedge core_clk) disable iff (srst)
    link_ev.bus_reset |=> !st_reg.remote_resume_request)
    else $error("resume request kept across bus reset");

  AST_LOW_SPEED: assert property (@(posedge core_clk) disable iff (srst)
    s_ctrl_write |=> low_speed_mode == $past(avm_req.writedata[`UDG_BIT_LOW_SPEED]))
    else $error("speed mode differs from force bit");

  AST_IDLE_SET: assert property (@(posedge core_clk) disable iff (srst)
    idle_done && !wake_set |=> st_reg.flags[`UDG_BIT_IDLE])
    else $error("idle flag not set after idle period");

  AST_MUTUAL: assert property (@(posedge core_clk) disable iff (srst)
    wake_set && !idle_set |=> !st_reg.flags[`UDG_BIT_IDLE] && st_reg.flags[`UDG_BIT_WAKE])
    else $error("wake did not clear idle flag");

  AST_SOF: assert property (@(posedge core_clk) disable iff (srst)
    link_ev.sof_seen |=> st_reg.flags[`UDG_BIT_SOF]
      && frame_number_field == $past(link_ev.frame_number))
    else $error("start of frame not recorded");

  AST_SET_WINS: assert property (@(posedge core_clk) disable iff (srst)
    link_ev.reset_end && clr_w[`UDG_BIT_RST] |=> st_reg.flags[`UDG_BIT_RST])
    else $error("clear beat a hardware set");

  AST_CLEAR: assert property (@(posedge core_clk) disable iff (srst)
    clr_w[`UDG_BIT_SOF] && !link_ev.sof_seen && !set_w[`UDG_BIT_SOF]
      |=> !st_reg.flags[`UDG_BIT_SOF])
    else $error("flag not cleared by clear write");

  AST_IRQ: assert property (@(posedge core_clk) disable iff (srst)
    $rose(st_reg.enables[`UDG_BIT_RST]) && st_reg.flags[`UDG_BIT_RST] |-> usb_irq)
    else $error("enabled flag gives no interrupt");

  AST_EP: assert property (@(posedge core_clk) disable iff (srst)
    1'b1 |=> st_reg.flags[`UDG_EP_LSB +: 7] == $past(link_ev.ep_irq))
    else $error("endpoint summary does not follow source");

  // ---------------------------------------------------------------
  // checks: control bits
  // ---------------------------------------------------------------
  AST_RESUME_WRITE: assert property (@(posedge core_clk) disable iff (srst)
    s_ctrl_write ##0 avm_req.writedata[`UDG_BIT_RESUME] ##0 s_no_resume_end
      |=> st_reg.remote_resume_request)
    else $error("resume request not taken");

  AST_RESUME_ZERO: assert property (@(posedge core_clk) disable iff (srst)
    s_ctrl_write ##0 st_reg.remote_resume_request ##0 s_no_resume_end |=> st_reg.remote_resume_request)
    else $error("write cleared resume request");

  AST_RESUME_DONE: assert property (@(posedge core_clk) disable iff (srst)
    s_resume_done |=> !st_reg.remote_resume_request && !upstream_resume_drive)
    else $error("resume request kept after resume sent");

  AST_DRIVE_ONLY_ON_REQ: assert property (@(posedge core_clk) disable iff (srst)
    !st_reg.remote_resume_request && st_reg.res_state == udg_pkg::UDG_RES_IDLE |=> !upstream_resume_drive)
    else $error("resume driven without request");

  AST_LS_HOLD: assert property (@(posedge core_clk) disable iff (srst)
    !wr_hit || avm_req.address != `UDG_OFF_CTRL || !avm_req.byteenable[1] |=> $stable(low_speed_mode))
    else $error("speed force changed without write");

  // ---------------------------------------------------------------
  // checks: flags, enables and bus
  // ---------------------------------------------------------------
  AST_IDLE_COUNT: assert property (@(posedge core_clk) disable iff (srst)
    !link_ev.line_j_idle |=> st_reg.idle_cnt == 32'h0)
    else $error("idle count not restarted");

  AST_IDLE_IRQ: assert property (@(posedge core_clk) disable iff (srst)
    st_reg.flags[`UDG_BIT_IDLE] && st_reg.enables[`UDG_BIT_IDLE] |-> usb_irq)
    else $error("idle flag gives no interrupt");

  AST_IDLE_CLEARS_WAKE: assert property (@(posedge core_clk) disable iff (srst)
    idle_set && !wake_set |=> st_reg.flags[`UDG_BIT_IDLE] && !st_reg.flags[`UDG_BIT_WAKE])
    else $error("idle did not clear wake flag");

  AST_FRAME_HOLD: assert property (@(posedge core_clk) disable iff (srst)
    !link_ev.sof_seen |=> $stable(frame_number_field))
    else $error("frame number changed without frame start");

  AST_RESET_END: assert property (@(posedge core_clk) disable iff (srst)
    link_ev.reset_end |=> st_reg.flags[`UDG_BIT_RST])
    else $error("reset end not recorded");

  AST_RESET_END_IRQ: assert property (@(posedge core_clk) disable iff (srst)
    st_reg.flags[`UDG_BIT_RST] && st_reg.enables[`UDG_BIT_RST] |-> usb_irq)
    else $error("reset end gives no interrupt");

  AST_WAKE_SET: assert property (@(posedge core_clk) disable iff (srst)
    link_ev.line_activity && !upstream_resume_drive && !idle_set |=> st_reg.flags[`UDG_BIT_WAKE])
    else $error("line activity not recorded");

  AST_WAKE_NOT_OWN: assert property (@(posedge core_clk) disable iff (srst)
    upstream_resume_drive && !set_w[`UDG_BIT_WAKE] && !st_reg.flags[`UDG_BIT_WAKE]
      |=> !st_reg.flags[`UDG_BIT_WAKE])
    else $error("own resume raised wake flag");

  AST_RESUME_END: assert property (@(posedge core_clk) disable iff (srst)
    link_ev.resume_end |=> st_reg.flags[`UDG_BIT_RSM])
    else $error("resume end not recorded");

  AST_UPSTREAM_FLAG: assert property (@(posedge core_clk) disable iff (srst)
    s_req_resume |=> st_reg.flags[`UDG_BIT_UPR])
    else $error("upstream resume flag not set");

  AST_DMA: assert property (@(posedge core_clk) disable iff (srst)
    1'b1 |=> st_reg.flags[`UDG_DMA_LSB +: 6]
      == ($past(link_ev.dma_irq) | $past(set_w[`UDG_DMA_LSB +: 6])))
    else $error("dma summary does not follow source");

  AST_IRQ_GATE: assert property (@(posedge core_clk) disable iff (srst)
    (st_reg.flags & st_reg.enables) == 32'h0 |-> !usb_irq)
    else $error("interrupt without enabled flag");

  AST_CLEAR_RST: assert property (@(posedge core_clk) disable iff (srst)
    clr_w[`UDG_BIT_RST] && !link_ev.reset_end && !set_w[`UDG_BIT_RST] |=> !st_reg.flags[`UDG_BIT_RST])
    else $error("reset end flag not cleared");

  AST_READ_ZERO: assert property (@(posedge core_clk) disable iff (srst)
    rd_hit && (avm_req.address == `UDG_OFF_CLEAR || avm_req.address == `UDG_OFF_SET)
      |=> avm_readdata == 32'h0)
    else $error("write-only register read not zero");

  AST_FORCE: assert property (@(posedge core_clk) disable iff (srst)
    set_w[`UDG_BIT_RSM] |=> st_reg.flags[`UDG_BIT_RSM])
    else $error("set register did not force flag");

  AST_RESERVED: assert property (@(posedge core_clk) disable iff (srst)
    1'b1 |-> (st_reg.flags & ~`UDG_VALID_MASK) == 32'h0)
    else $error("reserved flag bit set");

  AST_EN_CLEAR: assert property (@(posedge core_clk) disable iff (srst)
    wr_hit && avm_req.address == `UDG_OFF_EN_CLEAR && avm_req.byteenable[0]
      && avm_req.writedata[`UDG_BIT_SOF] |=> !st_reg.enables[`UDG_BIT_SOF])
    else $error("enable not cleared");

  AST_EN_SET: assert property (@(posedge core_clk) disable iff (srst)
    wr_hit && avm_req.address == `UDG_OFF_EN_SET && avm_req.byteenable[0]
      && avm_req.writedata[`UDG_BIT_SOF] |=> st_reg.enables[`UDG_BIT_SOF])
    else $error("enable not set");

  AST_EN_HOLD: assert property (@(posedge core_clk) disable iff (srst)
    !wr_hit |=> $stable(st_reg.enables))
    else $error("enables changed without write");

  AST_IRQ_HOLD: assert property (@(posedge core_clk) disable iff (srst)
    (st_reg.flags & st_reg.enables) != 32'h0 |-> usb_irq)
    else $error("interrupt dropped while enabled flag set");

  AST_SET_WINS_WAKE: assert property (@(posedge core_clk) disable iff (srst)
    wake_set && clr_w[`UDG_BIT_WAKE] |=> st_reg.flags[`UDG_BIT_WAKE])
    else $error("clear beat wake set");

  AST_READ_FLAGS: assert property (@(posedge core_clk) disable iff (srst)
    rd_hit && avm_req.address == `UDG_OFF_FLAGS |=> avm_readdata == $past(st_reg.flags))
    else $error("flag read returns wrong value");

  AST_WAIT_ONE: assert property (@(posedge core_clk) disable iff (srst)
    st_reg.ack |-> !avm_waitrequest)
    else $error("waitrequest held after ack");

  AST_NO_WAIT_IDLE: assert property (@(posedge core_clk) disable iff (srst)
    !avm_req.read && !avm_req.write |-> !avm_waitrequest)
    else $error("waitrequest without request");

  AST_ACK_ONE: assert property (@(posedge core_clk) disable iff (srst)
    st_reg.ack |=> !st_reg.ack)
    else $error("ack longer than one cycle");
endmodule // udg_global_irq

// File: tb/udg_host_model.sv
// usb host model that drives the link event inputs of the block
`timescale 1ns/100ps
module udg_host_model #(
  parameter int unsigned RSM_CYCLES = 12
) (
  input  wire logic             core_clk,
  input  wire logic             upstream_resume_drive,
  output udg_pkg::udg_link_ev_t link_ev
);
  int unsigned rsm_cnt;
  initial begin
    link_ev = '0;
    rsm_cnt = 0;
  end
  // ----------------------------------------
  // one-cycle events: 0 frame, 1 reset end, 2 resume end, else bus reset
  // ----------------------------------------
  task automatic pulse(input int sel, input logic [10:0] fn);
    link_ev.frame_number <= fn;
    case (sel)
      0: link_ev.sof_seen <= 1'b1;
      1: link_ev.reset_end <= 1'b1;
      2: link_ev.resume_end <= 1'b1;
      default: link_ev.bus_reset <= 1'b1;
    endcase
    @(posedge core_clk);
    {link_ev.sof_seen, link_ev.reset_end, link_ev.resume_end, link_ev.bus_reset} <= '0;
    @(posedge core_clk);
  endtask
  task automatic lines(input logic j, input logic act, input logic [6:0] ep,
                       input logic [5:0] dma);
    link_ev.line_j_idle   <= j;
    link_ev.line_activity <= act;
    link_ev.ep_irq        <= ep;
    link_ev.dma_irq       <= dma;
    @(posedge core_clk);
  endtask
  // resume is reported finished after a fixed run; the only early end here is a bus reset pulse
  always @(posedge core_clk) begin
    link_ev.resume_done <= (rsm_cnt == RSM_CYCLES);
    rsm_cnt <= upstream_resume_drive ? rsm_cnt + 1 : 0;
  end
endmodule // udg_host_model

// File: tb/tb_usb_device_global_irq_ctrl.sv
// testbench of the usb device global event block
`timescale 1ns/100ps
`include "udg_consts.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_usb_device_global_irq_ctrl;
  localparam int unsigned IDLE = 20;
  logic                  core_clk;
  logic                  srst;
  udg_pkg::udg_avm_req_t avm_req;
  logic [31:0]           avm_readdata;
  logic                  avm_waitrequest;
  udg_pkg::udg_link_ev_t link_ev;
  logic                  upstream_resume_drive;
  logic                  low_speed_mode;
  logic [10:0]           frame_number_field;
  logic                  usb_irq;
  int                    n_mismatch;
  int                    total_checks;
  int                    cycles = 0;
  logic [31:0]           rd;
  udg_global_irq #(.IDLE_CYCLES(IDLE)) dut (.core_clk(core_clk), .srst(srst),
    .avm_req(avm_req), .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest),
    .link_ev(link_ev), .upstream_resume_drive(upstream_resume_drive),
    .low_speed_mode(low_speed_mode), .frame_number_field(frame_number_field),
    .usb_irq(usb_irq));
  udg_host_model host (.core_clk(core_clk), .upstream_resume_drive(upstream_resume_drive),
    .link_ev(link_ev));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // holds the request until waitrequest is seen low, then lets an edge pass
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    avm_req <= '{address: a, read: ~wr, write: wr, writedata: d, byteenable: 4'hf};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avm_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) n_mismatch++;
    rd = avm_readdata;
    avm_req.read <= 1'b0;
    avm_req.write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    `CHK(rd, e)
  endtask
  task automatic irq(input logic e);
    repeat (2) @(posedge core_clk);
    `CHK(usb_irq, e)
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    avm_req = '0;
    srst = 1'b1;
    n_mismatch = 0;
    total_checks = 0;
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rchk(`UDG_OFF_FLAGS, 32'h0);
    rchk(`UDG_OFF_CLEAR, 32'h0);
    rchk(`UDG_OFF_SET, 32'h0);
    rchk(`UDG_OFF_EN_CLEAR, 32'h0);
    rchk(6'h1c, 32'h0);
    $display("test reset done");
    bus(1'b1, `UDG_OFF_EN_SET, `UDG_VALID_MASK);
    rchk(`UDG_OFF_ENABLE, `UDG_VALID_MASK);
    irq(1'b0);
    bus(1'b1, `UDG_OFF_SET, 32'h0000006c);
    rchk(`UDG_OFF_FLAGS, 32'h0000006c);
    irq(1'b1);
    bus(1'b1, `UDG_OFF_CLEAR, 32'h00000068);
    rchk(`UDG_OFF_FLAGS, 32'h00000004);
    bus(1'b1, `UDG_OFF_EN_CLEAR, 32'h00000004);
    irq(1'b0);
    bus(1'b1, `UDG_OFF_CLEAR, 32'h00000004);
    bus(1'b1, `UDG_OFF_EN_SET, 32'h00000004);
    $display("test registers done");
    host.pulse(0, 11'h5a3);
    rchk(`UDG_OFF_FLAGS, 32'h00000004);
    `CHK(frame_number_field, 11'h5a3)
    host.pulse(1, 11'h000);
    rchk(`UDG_OFF_FLAGS, 32'h0000000c);
    host.pulse(2, 11'h000);
    rchk(`UDG_OFF_FLAGS, 32'h0000002c);
    bus(1'b1, `UDG_OFF_CLEAR, 32'h0000002c);
    irq(1'b0);
    host.lines(1'b1, 1'b0, 7'h00, 6'h00);
    repeat (IDLE - 6) @(posedge core_clk);
    rchk(`UDG_OFF_FLAGS, 32'h0);
    repeat (8) @(posedge core_clk);
    rchk(`UDG_OFF_FLAGS, 32'h00000001);
    irq(1'b1);
    host.lines(1'b0, 1'b1, 7'h00, 6'h00);
    rchk(`UDG_OFF_FLAGS, 32'h00000010);
    host.lines(1'b1, 1'b0, 7'h00, 6'h00);
    repeat (IDLE + 4) @(posedge core_clk);
    rchk(`UDG_OFF_FLAGS, 32'h00000001);
    host.lines(1'b0, 1'b0, 7'h41, 6'h21);
    bus(1'b1, `UDG_OFF_CLEAR, 32'h0000007d);
    rchk(`UDG_OFF_FLAGS, 32'h42041000);
    host.lines(1'b0, 1'b0, 7'h00, 6'h00);
    repeat (2) @(posedge core_clk);
    rchk(`UDG_OFF_FLAGS, 32'h0);
    $display("test link events done");
    bus(1'b1, `UDG_OFF_CTRL, 32'h00001200);
    @(posedge core_clk);
    `CHK(upstream_resume_drive, 1'b1)
    `CHK(low_speed_mode, 1'b1)
    bus(1'b1, `UDG_OFF_CTRL, 32'h00001000);
    `CHK(upstream_resume_drive, 1'b1)
    for (int i = 0; i < 40 && upstream_resume_drive !== 1'b0; i++) @(posedge core_clk);
    rchk(`UDG_OFF_CTRL, 32'h00001000);
    rchk(`UDG_OFF_FLAGS, 32'h00000040);
    bus(1'b1, `UDG_OFF_CTRL, 32'h00001200);
    host.pulse(3, 11'h000);
    rchk(`UDG_OFF_CTRL, 32'h00001000);
    bus(1'b1, `UDG_OFF_CTRL, 32'h00000000);
    `CHK(low_speed_mode, 1'b0)
    $display("test resume done");
    end_sim();
  end
endmodule // tb_usb_device_global_irq_ctrl
